// ===== common/ceirq_consts.svh
// Constants for the clock event flag and interrupt enable block
`ifndef CEIRQ_CONSTS_SVH
`define CEIRQ_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CEIRQ_ADDR_W       12
`define CEIRQ_DATA_W       32
`define CEIRQ_NUM_EVT      6

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CEIRQ_OFS_HF_XTAL  12'h100
`define CEIRQ_OFS_LF_CLK   12'h104
`define CEIRQ_OFS_CAL_DONE 12'h10c
`define CEIRQ_OFS_CT_TMO   12'h110
`define CEIRQ_OFS_CT_STRT  12'h128
`define CEIRQ_OFS_CT_STOP  12'h12c
`define CEIRQ_OFS_IRQ_STAT 12'h300
`define CEIRQ_OFS_IEN_SET  12'h304
`define CEIRQ_OFS_IEN_CLR  12'h308

// ----------------------------------------------------------------------
// Event bit positions, shared by enable and status registers, and the bit of each flag register
// ----------------------------------------------------------------------
`define CEIRQ_BIT_HF_XTAL  0
`define CEIRQ_BIT_LF_CLK   1
`define CEIRQ_BIT_CAL_DONE 2
`define CEIRQ_BIT_CT_TMO   3
`define CEIRQ_BIT_CT_STRT  4
`define CEIRQ_BIT_CT_STOP  5
`define CEIRQ_BIT_FLAG     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CEIRQ_RST_EVT      6'h00
`define CEIRQ_RST_FLAG     1'h0
`define CEIRQ_RST_DATA     32'h0000_0000

`endif

// ===== common/ceirq_pkg.sv
// Types for the clock event flag and interrupt enable block
`include "ceirq_consts.svh"

package ceirq_pkg;

  // Event vector, one bit per oscillator or calibration event
  typedef logic [`CEIRQ_NUM_EVT-1:0] ceirq_evt_t;

  // APB request as seen by the register decoder
  typedef struct packed {
    logic [`CEIRQ_ADDR_W-1:0] addr;
    logic                     write;
    logic [3:0]               strb;
    logic [`CEIRQ_DATA_W-1:0] wdata;
  } ceirq_req_s;

  // Registered APB answer
  typedef struct packed {
    logic                     ready;
    logic                     slverr;
    logic [`CEIRQ_DATA_W-1:0] rdata;
  } ceirq_rsp_s;

endpackage

// ===== hw/ceirq_flag.sv
// One event flag: set by hardware, written by software
`timescale 1ns/1ps
`include "ceirq_consts.svh"

module ceirq_flag (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Hardware event and software write
  input  wire logic evt_set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  // Flag state
  output logic      flag
);

  logic flag_r;
  logic flag_nxt;

  // Event wins over a software write in the same cycle, so none is lost
  always_comb begin
    flag_nxt = flag_r;
    if (wr_en) begin
      flag_nxt = wr_val;
    end
    if (evt_set) begin
      flag_nxt = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= `CEIRQ_RST_FLAG;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule // ceirq_flag

// ===== hw/ceirq_top.sv
// Clock controller event flags, interrupt enables and APB slave
//
// Functional notes
// R1: Crystal started flag reads one once set
// R2: Calibration done flag set on completion
// R3: Timer started flag set on timer start
// R4: Timer stopped flag set on timer stop
// R5: Enable-set bit A enables, reads state
// R6: Enable-set bit B enables clock-started irq
// R7: Enable-set bit D enables timeout irq
// R8: Enable-set bit F enables stopped irq
// R9: Enable-clear register disables, reads same state
// R10: Zero to enable-set ignored; zero clears flag
`timescale 1ns/1ps
`include "ceirq_consts.svh"

module ceirq_top (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`CEIRQ_ADDR_W-1:0] paddr,
  input  wire logic [3:0]               pstrb,
  input  wire logic [`CEIRQ_DATA_W-1:0] pwdata,
  output logic      [`CEIRQ_DATA_W-1:0] prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Event pulses from oscillator and calibration logic, same clock
  input  wire logic                     hf_xtal_started,
  input  wire logic                     lf_clock_started,
  input  wire logic                     cal_done,
  input  wire logic                     cal_timer_timeout,
  input  wire logic                     cal_timer_started,
  input  wire logic                     cal_timer_stopped,
  // Interrupt
  output logic                          clk_irq
);

  // --------------------------------------------------------------------
  // Request capture
  // --------------------------------------------------------------------
  ceirq_pkg::ceirq_req_s req;
  ceirq_pkg::ceirq_rsp_s rsp_r;
  ceirq_pkg::ceirq_rsp_s rsp_nxt;
  ceirq_pkg::ceirq_evt_t evt;
  ceirq_pkg::ceirq_evt_t flags;
  ceirq_pkg::ceirq_evt_t flag_wr;
  ceirq_pkg::ceirq_evt_t ien_r;
  ceirq_pkg::ceirq_evt_t ien_nxt;
  ceirq_pkg::ceirq_evt_t stat_r;
  ceirq_pkg::ceirq_evt_t stat_nxt;
  logic                  irq_r;
  logic                  irq_nxt;
  logic                  setup;
  logic                  done;
  logic                  wr_done;
  logic                  wr_low;
  logic                  rd_stat;
  logic                  hit;
  logic [`CEIRQ_DATA_W-1:0] rd_val;

  // Bundle the bus fields so the decode sees one request
  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.strb  = pstrb;
  assign req.wdata = pwdata;

  // Event vector in register bit order
  assign evt[`CEIRQ_BIT_HF_XTAL]  = hf_xtal_started;
  assign evt[`CEIRQ_BIT_LF_CLK]   = lf_clock_started;
  assign evt[`CEIRQ_BIT_CAL_DONE] = cal_done;
  assign evt[`CEIRQ_BIT_CT_TMO]   = cal_timer_timeout;
  assign evt[`CEIRQ_BIT_CT_STRT]  = cal_timer_started;
  assign evt[`CEIRQ_BIT_CT_STOP]  = cal_timer_stopped;

  // Phase decode: answer is built in setup, taken at the access edge
  assign setup   = psel & ~penable;
  assign done    = psel & penable & rsp_r.ready;
  assign wr_done = done & req.write & ~rsp_r.slverr;
  // All fields live in byte lane zero; other lanes carry nothing
  assign wr_low  = wr_done & req.strb[0];
  assign rd_stat = done & ~req.write & ~rsp_r.slverr &
                   (req.addr == `CEIRQ_OFS_IRQ_STAT);

  // --------------------------------------------------------------------
  // Read mux and address decode
  // --------------------------------------------------------------------
  // Flags read as one in bit zero, upper bits read zero
  always_comb begin
    rd_val = `CEIRQ_RST_DATA;
    hit    = 1'b1;
    case (req.addr)
      `CEIRQ_OFS_HF_XTAL: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_HF_XTAL];  // [R1]
      end
      `CEIRQ_OFS_LF_CLK: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_LF_CLK];
      end
      `CEIRQ_OFS_CAL_DONE: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_CAL_DONE]; // [R2]
      end
      `CEIRQ_OFS_CT_TMO: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_CT_TMO];
      end
      `CEIRQ_OFS_CT_STRT: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_CT_STRT];  // [R3]
      end
      `CEIRQ_OFS_CT_STOP: begin
        rd_val[`CEIRQ_BIT_FLAG] = flags[`CEIRQ_BIT_CT_STOP];  // [R4]
      end
      `CEIRQ_OFS_IRQ_STAT: begin
        rd_val[`CEIRQ_NUM_EVT-1:0] = stat_r;
      end
      // Both enable views show the same state
      `CEIRQ_OFS_IEN_SET, `CEIRQ_OFS_IEN_CLR: begin
        rd_val[`CEIRQ_NUM_EVT-1:0] = ien_r;                  // [R5] [R9]
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------
  // No wait state: read data and pready are both registered at the end of setup
  always_comb begin
    rsp_nxt        = rsp_r;
    rsp_nxt.ready  = setup;
    if (setup) begin
      rsp_nxt.slverr = ~hit;
      rsp_nxt.rdata  = req.write ? `CEIRQ_RST_DATA : rd_val;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_r.ready  <= 1'b0;
      rsp_r.slverr <= 1'b0;
      rsp_r.rdata  <= `CEIRQ_RST_DATA;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign prdata  = rsp_r.rdata;
  assign pready  = rsp_r.ready;
  assign pslverr = rsp_r.slverr;

  // --------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------
  // Software write of zero clears a flag, an event in that cycle wins
  assign flag_wr[`CEIRQ_BIT_HF_XTAL]  = wr_low &
                                        (req.addr == `CEIRQ_OFS_HF_XTAL);
  assign flag_wr[`CEIRQ_BIT_LF_CLK]   = wr_low &
                                        (req.addr == `CEIRQ_OFS_LF_CLK);
  assign flag_wr[`CEIRQ_BIT_CAL_DONE] = wr_low &
                                        (req.addr == `CEIRQ_OFS_CAL_DONE);
  assign flag_wr[`CEIRQ_BIT_CT_TMO]   = wr_low &
                                        (req.addr == `CEIRQ_OFS_CT_TMO);
  assign flag_wr[`CEIRQ_BIT_CT_STRT]  = wr_low &
                                        (req.addr == `CEIRQ_OFS_CT_STRT);
  assign flag_wr[`CEIRQ_BIT_CT_STOP]  = wr_low &
                                        (req.addr == `CEIRQ_OFS_CT_STOP);

  // One flag cell per event
  genvar gi;
  generate
    for (gi = 0; gi < `CEIRQ_NUM_EVT; gi++) begin : g_flag
      ceirq_flag u_flag (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .evt_set (evt[gi]),                                  // [R1] [R2]
        .wr_en   (flag_wr[gi]),                              // [R10]
        .wr_val  (req.wdata[`CEIRQ_BIT_FLAG]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Interrupt enables, status and output
  // --------------------------------------------------------------------
  // Ones set or clear enables; zeros leave them alone
  always_comb begin
    ien_nxt = ien_r;
    if (wr_low && req.addr == `CEIRQ_OFS_IEN_SET) begin
      ien_nxt = ien_r | req.wdata[`CEIRQ_NUM_EVT-1:0]; // [R5][R6][R7][R8][R10]
    end
    if (wr_low && req.addr == `CEIRQ_OFS_IEN_CLR) begin
      ien_nxt = ien_r & ~req.wdata[`CEIRQ_NUM_EVT-1:0];      // [R9]
    end
  end

  // Read clears only the bits returned, so a late event stays pending
  always_comb begin
    stat_nxt = stat_r;
    if (rd_stat) begin
      stat_nxt = stat_r & ~rsp_r.rdata[`CEIRQ_NUM_EVT-1:0];
    end
    stat_nxt = stat_nxt | evt;
    irq_nxt  = |(stat_nxt & ien_nxt);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ien_r  <= `CEIRQ_RST_EVT;
      stat_r <= `CEIRQ_RST_EVT;
      irq_r  <= 1'b0;
    end else begin
      ien_r  <= ien_nxt;
      stat_r <= stat_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign clk_irq = irq_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic wr_set;
  logic wr_clr;
  assign wr_set = wr_low && req.addr == `CEIRQ_OFS_IEN_SET;
  assign wr_clr = wr_low && req.addr == `CEIRQ_OFS_IEN_CLR;

  chk_hfx_flag: assert property ( // [R1]
    hf_xtal_started |=> flags[`CEIRQ_BIT_HF_XTAL] ##1
      (!psel || rsp_r.rdata[`CEIRQ_BIT_FLAG] ||
       req.addr != `CEIRQ_OFS_HF_XTAL || req.write || !rsp_r.ready ||
       flag_wr[`CEIRQ_BIT_HF_XTAL]))
    else $error("crystal started flag not set by event");

  chk_done_flag: assert property ( // [R2]
    cal_done |=> flags[`CEIRQ_BIT_CAL_DONE])
    else $error("calibration done flag not set by event");

  chk_strt_flag: assert property ( // [R3]
    cal_timer_started |=> flags[`CEIRQ_BIT_CT_STRT])
    else $error("timer started flag not set by event");

  chk_stop_flag: assert property ( // [R4]
    cal_timer_stopped |=> flags[`CEIRQ_BIT_CT_STOP])
    else $error("timer stopped flag not set by event");

  chk_flag_quiet: assert property ( // [R1]
    !flags[`CEIRQ_BIT_HF_XTAL] && !hf_xtal_started &&
      !flag_wr[`CEIRQ_BIT_HF_XTAL]
      |=> !flags[`CEIRQ_BIT_HF_XTAL])
    else $error("crystal started flag set without event");

  chk_ien_hfx: assert property ( // [R5]
    wr_set && req.wdata[`CEIRQ_BIT_HF_XTAL]
      |=> ien_r[`CEIRQ_BIT_HF_XTAL] ##1 ien_r[`CEIRQ_BIT_HF_XTAL] || wr_clr)
    else $error("enable set did not enable crystal irq");

  chk_ien_lfc: assert property ( // [R6]
    wr_set && req.wdata[`CEIRQ_BIT_LF_CLK] |=> ien_r[`CEIRQ_BIT_LF_CLK])
    else $error("enable set did not enable clock started irq");

  chk_ien_tmo: assert property ( // [R7]
    wr_set && req.wdata[`CEIRQ_BIT_CT_TMO] |=> ien_r[`CEIRQ_BIT_CT_TMO])
    else $error("enable set did not enable timeout irq");

  chk_ien_stop: assert property ( // [R8]
    wr_set && req.wdata[`CEIRQ_BIT_CT_STOP] |=> ien_r[`CEIRQ_BIT_CT_STOP])
    else $error("enable set did not enable stopped irq");

  chk_ien_clear: assert property ( // [R9]
    wr_clr && req.wdata[`CEIRQ_BIT_CAL_DONE]
      |=> !ien_r[`CEIRQ_BIT_CAL_DONE])
    else $error("enable clear did not disable irq");

  chk_ien_zero: assert property ( // [R10]
    wr_set && !req.wdata[`CEIRQ_BIT_CT_STRT]
      |=> ien_r[`CEIRQ_BIT_CT_STRT] == $past(ien_r[`CEIRQ_BIT_CT_STRT]))
    else $error("zero write changed an enable");

  chk_flag_clear: assert property ( // [R10]
    flag_wr[`CEIRQ_BIT_CT_TMO] && !req.wdata[`CEIRQ_BIT_FLAG] &&
      !cal_timer_timeout |=> !flags[`CEIRQ_BIT_CT_TMO])
    else $error("zero write did not clear flag");

  chk_ready_wait: assert property (
    setup |=> pready ##1 !pready || setup)
    else $error("pready not given one cycle after setup");

  // Checked from the event inputs, not from the status copy it is built on
  chk_irq_level: assert property (
    (evt & ien_r) != `CEIRQ_RST_EVT && !wr_clr |=> clk_irq)
    else $error("interrupt low after enabled event");

  cov_irq_rise: cover property (ien_r != `CEIRQ_RST_EVT ##1 $rose(clk_irq));
  cov_stat_read: cover property (rd_stat && stat_r != `CEIRQ_RST_EVT);
  cov_evt_clash: cover property (flag_wr[`CEIRQ_BIT_CAL_DONE] && cal_done);
  cov_slverr: cover property (done && pslverr);

endmodule // ceirq_top

// ===== tb/ceirq_top_test.sv
// Self-checking bench for the clock event flag and interrupt block
`timescale 1ns/1ps
`include "ceirq_consts.svh"

module ceirq_top_test;
  // ------------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------------
  localparam logic [11:0] A_SET  = `CEIRQ_OFS_IEN_SET;
  localparam logic [11:0] A_CLR  = `CEIRQ_OFS_IEN_CLR;
  localparam logic [11:0] A_STAT = `CEIRQ_OFS_IRQ_STAT;
  logic        sys_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  evt;
  logic        clk_irq;
  logic [11:0] ofs [0:5];
  logic [31:0] pwd;
  logic [5:0]  mask;
  logic [31:0] q_data [$];
  logic        q_err [$];
  string       q_name [$];
  integer      fails;
  integer      n_checks;
  integer      cyc;
  integer      seed;

  ceirq_top dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_xtal_started(evt[0]), .lf_clock_started(evt[1]),
    .cal_done(evt[2]), .cal_timer_timeout(evt[3]),
    .cal_timer_started(evt[4]), .cal_timer_stopped(evt[5]),
    .clk_irq(clk_irq)
  );

  // ------------------------------------------------------------------
  // Clock, timeout and compare tasks
  // ------------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // A hung handshake would stall the queue forever, so cap the run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      stop_test;
    end
  end

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s data expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s bit expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic stop_test;
    if (q_err.size() != 0) fails++;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Drivers: APB transfer and event pulse, called just after an edge
  // ------------------------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic wr,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    q_data.push_back(exp);
    q_err.push_back(err);
    q_name.push_back($sformatf("%s %h", wr ? "write" : "read", a));
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse(input int i, input logic exp_irq);
    evt <= 6'h01 << i;
    @(posedge sys_clk);
    evt <= 6'h00;
    // Interrupt registers on the event edge; read it at the next edge
    @(posedge sys_clk);
    chk_bit("irq after event", exp_irq, clk_irq);
  endtask

  // Monitor: completion edge pops the oldest note and compares
  always @(posedge sys_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        q_err.size() > 0) begin
      chk_word(q_name[0], q_data.pop_front(), prdata);
      chk_bit(q_name.pop_front(), q_err.pop_front(), pslverr);
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h14c8a28e;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pstrb = 4'hf;
    pwdata = 32'h0000_0000;
    evt = 6'h00;
    ofs[0] = `CEIRQ_OFS_HF_XTAL;
    ofs[1] = `CEIRQ_OFS_LF_CLK;
    ofs[2] = `CEIRQ_OFS_CAL_DONE;
    ofs[3] = `CEIRQ_OFS_CT_TMO;
    ofs[4] = `CEIRQ_OFS_CT_STRT;
    ofs[5] = `CEIRQ_OFS_CT_STOP;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    // All six flags and both enable views read zero out of reset
    for (int i = 0; i < 6; i++) apb(ofs[i], 1'b0, 0, 0, 1'b0);
    apb(A_SET, 1'b0, 0, 0, 1'b0);
    apb(A_CLR, 1'b0, 0, 0, 1'b0);
    $display("test reset_values done");
    // Each event sets its own flag and only its own status bit; a zero write with junk above clears
    for (int i = 0; i < 6; i++) begin
      pulse(i, 1'b0);
      apb(ofs[i], 1'b0, 0, 1, 1'b0);
      pwd = $random(seed);
      pwd[0] = 1'b0;
      apb(ofs[i], 1'b1, pwd, 0, 1'b0);
      apb(ofs[i], 1'b0, 0, 0, 1'b0);
      apb(A_STAT, 1'b0, 0, 32'h1 << i, 1'b0);
    end
    $display("test event_flags done");
    // Random enables, then their complement, so every bit goes both ways
    for (int p = 0; p < 2; p++) begin
      pwd = $random(seed);
      if (p == 1) pwd[5:0] = ~mask;
      mask = pwd[5:0];
      apb(A_CLR, 1'b1, 32'h3f, 0, 1'b0);
      apb(A_SET, 1'b0, 0, 0, 1'b0);
      apb(A_SET, 1'b1, pwd, 0, 1'b0);
      apb(A_SET, 1'b1, 0, 0, 1'b0);
      apb(A_CLR, 1'b0, 0, {26'h0, mask}, 1'b0);
      for (int i = 0; i < 6; i++) begin
        pulse(i, mask[i]);
        apb(A_STAT, 1'b0, 0, 32'h1 << i, 1'b0);
        chk_bit("irq after status read", 1'b0, clk_irq);
        apb(ofs[i], 1'b1, 0, 0, 1'b0);
      end
    end
    $display("test irq_enables done");
    // Refused and ignored accesses
    apb(12'h200, 1'b0, 0, 0, 1'b1);
    apb(12'h200, 1'b1, 32'hffff_ffff, 0, 1'b1);
    apb(A_STAT, 1'b1, 32'h3f, 0, 1'b0);
    apb(A_STAT, 1'b0, 0, 0, 1'b0);
    pstrb <= 4'he;
    apb(ofs[0], 1'b1, 1, 0, 1'b0);
    pstrb <= 4'hf;
    apb(ofs[0], 1'b0, 0, 0, 1'b0);
    apb(ofs[0], 1'b1, 1, 0, 1'b0);
    apb(ofs[0], 1'b0, 0, 1, 1'b0);
    $display("test refusals done");
    // Reset in mid-run drops enables, flags and the interrupt at once
    apb(A_SET, 1'b1, 32'h3f, 0, 1'b0);
    pulse(2, 1'b1);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    chk_bit("irq in reset", 1'b0, clk_irq);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    apb(A_SET, 1'b0, 0, 0, 1'b0);
    apb(ofs[2], 1'b0, 0, 0, 1'b0);
    apb(A_STAT, 1'b0, 0, 0, 1'b0);
    $display("test mid_reset done");
    stop_test;
  end
endmodule // ceirq_top_test
